// [rtl/event_flag.sv]
// One sticky event flag, set by hardware and cleared by software.
`timescale 1ns/100ps

module event_flag
(
	input  wire logic clk,
	input  wire logic reset,
	input  wire logic set_evt,
	input  wire logic latch_en,
	input  wire logic clr,
	output logic      q
);

	logic q_r;
	logic q_nxt;

	// The set is tested last so an event in the clearing cycle is kept.
	always_comb
	begin
		q_nxt = q_r;
		if (clr)
			q_nxt = 1'b0;
		if (set_evt && latch_en)
			q_nxt = 1'b1;
	end

	// Flag storage.
	always_ff @(posedge clk)
	begin
		if (reset)
			q_r <= 1'b0;
		else
			q_r <= q_nxt;
	end

	assign q = q_r;

endmodule : event_flag

// [rtl/evt_map.svh]
// Offsets, field positions, reset values and timing counts of the event bank.
`ifndef EVT_MAP_SVH
`define EVT_MAP_SVH

// Register indices; the byte address on the bus is four times the index.
`define EVT_IDX_NSTAT      6'h30
`define EVT_IDX_ESTAT      6'h32
`define EVT_IDX_LATCH_EN   6'h34
`define EVT_IDX_MASK       6'h38
`define EVT_IDX_CTRL       6'h3C

// Positions of the flags in the normal event status register.
`define EVT_BIT_CMD_DONE   0
`define EVT_BIT_XFER_DONE  1
`define EVT_BIT_GAP        2
`define EVT_BIT_DMA        3
`define EVT_BIT_BUF_WR     4
`define EVT_BIT_ERR_SUM    15

// Positions in the error status and control registers.
`define EVT_BIT_CMD_TMO    0
`define EVT_BIT_ADMA_SEL   0

// Reset values.
`define EVT_LATCH_EN_RST   16'h001F
`define EVT_MASK_RST       16'h0000
`define EVT_CTRL_RST       16'h0000

// Card clock cycles allowed between a command and its response.
`define EVT_RESP_WAIT_CLKS 64

`endif

// [rtl/evt_pkg.sv]
// Types shared by the event bank.
package evt_pkg;

	// States of the response wait watchdog.
	typedef enum logic [0:0] {
		WAIT_IDLE = 1'b0,
		WAIT_RESP = 1'b1
	} wait_state_e;

	// Number of hardware flags, five normal events and the timeout.
	localparam int NUM_FLAGS = 6;

	typedef logic [NUM_FLAGS-1:0] flag_vec_t;

endpackage : evt_pkg

// [rtl/normal_event_bank.sv]
// Normal event status bank with response watchdog and Wishbone slave.
// ****************************************************************
// Notes on behaviour
// RULE_01: Buffer write ready sets on a rising buffer write enable.
// RULE_02: Simple DMA sets the DMA flag at a boundary, not on last block.
// RULE_03: Advanced DMA sets the DMA flag after a descriptor asking for it.
// RULE_04: With gap stop requested, gap event sets when the transfer halts.
// RULE_05: Read transfer complete sets when read transfer active falls.
// RULE_06: Write transfer complete sets when data line active falls.
// RULE_07: Transfer complete sets when the card releases busy.
// RULE_08: Transfer complete also sets on a halt at the block gap.
// RULE_09: Command complete sets when a response arrives with good CRC.
// RULE_10: Automatic stop and block count commands never set command complete.
// RULE_11: No response within 64 card clocks raises command timeout.
// RULE_12: Software ranks timeout above command complete.
// RULE_13: Software reads both clear as another interrupt source.
// RULE_14: A flag latches only while its latch enable bit is one; the timeout flag has no enable bit here and always latches.
// RULE_15: Flags reset to zero; writing one clears, writing zero keeps.
// ****************************************************************
//
// The register offsets and register access over Wishbone were left to the implementer.
`timescale 1ns/100ps
`include "evt_map.svh"

module normal_event_bank
	import evt_pkg::*;
#(
	parameter int RESP_WAIT_CLKS = `EVT_RESP_WAIT_CLKS
)
(
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic [3:0]  wb_sel_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        buf_write_enable,
	input  wire logic        read_xfer_active,
	input  wire logic        write_xfer_active,
	input  wire logic        data_line_active,
	input  wire logic        read_direction,
	input  wire logic        gap_stop_request,
	input  wire logic        sdma_boundary_hit,
	input  wire logic        sdma_last_block,
	input  wire logic        adma_desc_done,
	input  wire logic        adma_desc_int,
	input  wire logic        busy_released,
	input  wire logic        cmd_issued,
	input  wire logic        resp_received,
	input  wire logic        resp_crc_ok,
	input  wire logic        resp_auto_cmd,
	input  wire logic        card_clk_tick,
	output logic             cmd_timeout,
	output logic             irq
);

	localparam int CW        = $clog2(RESP_WAIT_CLKS);
	localparam int LAST_TICK = RESP_WAIT_CLKS - 1;

	// ****************************************************************
	// Edge detection of present state bits
	// ****************************************************************

	logic bwe_d_r;
	logic rda_d_r;
	logic wra_d_r;
	logic dla_d_r;
	logic bwe_d_nxt;
	logic rda_d_nxt;
	logic wra_d_nxt;
	logic dla_d_nxt;

	// The state bits come from logic on this clock, so no synchroniser.
	always_comb
	begin
		bwe_d_nxt = buf_write_enable;
		rda_d_nxt = read_xfer_active;
		wra_d_nxt = write_xfer_active;
		dla_d_nxt = data_line_active;
	end

	// Previous values of the state bits.
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			bwe_d_r <= 1'b0;
			rda_d_r <= 1'b0;
			wra_d_r <= 1'b0;
			dla_d_r <= 1'b0;
		end
		else
		begin
			bwe_d_r <= bwe_d_nxt;
			rda_d_r <= rda_d_nxt;
			wra_d_r <= wra_d_nxt;
			dla_d_r <= dla_d_nxt;
		end
	end

	logic bwe_rise;
	logic rda_fall;
	logic wra_fall;
	logic dla_fall;

	// Single cycle edges.
	assign bwe_rise = buf_write_enable & ~bwe_d_r;
	assign rda_fall = ~read_xfer_active & rda_d_r;
	assign wra_fall = ~write_xfer_active & wra_d_r;
	assign dla_fall = ~data_line_active & dla_d_r;

	// ****************************************************************
	// Response watchdog
	// ****************************************************************

	wait_state_e   wstate_r;
	wait_state_e   wstate_nxt;
	logic [CW-1:0] wait_cnt_r;
	logic [CW-1:0] wait_cnt_nxt;
	logic          tmo_evt;

	// Counts card clock ticks after a command until a response arrives.
	always_comb
	begin
		wstate_nxt   = wstate_r;
		wait_cnt_nxt = wait_cnt_r;
		tmo_evt      = 1'b0;
		case (wstate_r)
			WAIT_IDLE:
			begin
				if (cmd_issued)
				begin
					wstate_nxt   = WAIT_RESP;
					wait_cnt_nxt = '0;
				end
			end
			WAIT_RESP:
			begin
				if (resp_received)
					wstate_nxt = WAIT_IDLE;
				else if (card_clk_tick)
				begin
					if (wait_cnt_r == CW'(LAST_TICK)) // RULE_11
					begin
						tmo_evt    = 1'b1;
						wstate_nxt = WAIT_IDLE;
					end
					else
						wait_cnt_nxt = wait_cnt_r + 1'b1;
				end
			end
			default:
				wstate_nxt = WAIT_IDLE;
		endcase
	end

	// Watchdog state.
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			wstate_r   <= WAIT_IDLE;
			wait_cnt_r <= '0;
		end
		else
		begin
			wstate_r   <= wstate_nxt;
			wait_cnt_r <= wait_cnt_nxt;
		end
	end

	// ****************************************************************
	// Wishbone slave and software registers
	// ****************************************************************

	logic        ack_r;
	logic        ack_nxt;
	logic [31:0] dat_r;
	logic [31:0] dat_nxt;
	logic [15:0] latch_en_r;
	logic [15:0] latch_en_nxt;
	logic [15:0] mask_r;
	logic [15:0] mask_nxt;
	logic [15:0] ctrl_r;
	logic [15:0] ctrl_nxt;
	logic [15:0] nstat;
	logic [15:0] estat;
	logic        req;
	logic        wr_take;
	flag_vec_t   flags;
	flag_vec_t   clr_vec;

	// Merges the written low lanes into a register value.
	function automatic logic [15:0] lane_merge(input logic [15:0] old);
		lane_merge = old;
		if (wb_sel_i[0])
			lane_merge[7:0] = wb_dat_i[7:0];
		if (wb_sel_i[1])
			lane_merge[15:8] = wb_dat_i[15:8];
	endfunction : lane_merge

	// Index match for a register.
	function automatic logic hit(input logic [5:0] idx);
		hit = (wb_adr_i[7:2] == idx);
	endfunction : hit

	assign req     = wb_cyc_i & wb_stb_i;
	assign wr_take = req & wb_we_i & ack_r;

	// Readable views; the error summary bit mirrors any error flag.
	always_comb
	begin
		nstat = '0;
		estat = '0;
		nstat[`EVT_BIT_BUF_WR:`EVT_BIT_CMD_DONE] = flags[4:0];
		estat[`EVT_BIT_CMD_TMO]                  = flags[5];
		nstat[`EVT_BIT_ERR_SUM]                  = |estat;
	end

	// Writes act at the acknowledging edge; unmapped reads return zero.
	always_comb
	begin
		ack_nxt      = req & ~ack_r;
		dat_nxt      = dat_r;
		latch_en_nxt = latch_en_r;
		mask_nxt     = mask_r;
		ctrl_nxt     = ctrl_r;
		clr_vec      = '0;
		if (req && !ack_r)
		begin
			dat_nxt = 32'h0000_0000;
			if (hit(`EVT_IDX_NSTAT))
				dat_nxt[15:0] = nstat;
			else if (hit(`EVT_IDX_ESTAT))
				dat_nxt[15:0] = estat;
			else if (hit(`EVT_IDX_LATCH_EN))
				dat_nxt[15:0] = latch_en_r;
			else if (hit(`EVT_IDX_MASK))
				dat_nxt[15:0] = mask_r;
			else if (hit(`EVT_IDX_CTRL))
				dat_nxt[15:0] = ctrl_r;
		end
		if (wr_take)
		begin
			if (hit(`EVT_IDX_NSTAT) && wb_sel_i[0])
				clr_vec[4:0] = wb_dat_i[4:0]; // RULE_15
			if (hit(`EVT_IDX_ESTAT) && wb_sel_i[0])
				clr_vec[5] = wb_dat_i[`EVT_BIT_CMD_TMO];
			if (hit(`EVT_IDX_LATCH_EN))
				latch_en_nxt = lane_merge(latch_en_r);
			if (hit(`EVT_IDX_MASK))
				mask_nxt = lane_merge(mask_r);
			if (hit(`EVT_IDX_CTRL))
				ctrl_nxt = lane_merge(ctrl_r);
		end
	end

	// Bus and software register storage.
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			ack_r      <= 1'b0;
			dat_r      <= 32'h0000_0000;
			latch_en_r <= `EVT_LATCH_EN_RST;
			mask_r     <= `EVT_MASK_RST;
			ctrl_r     <= `EVT_CTRL_RST;
		end
		else
		begin
			ack_r      <= ack_nxt;
			dat_r      <= dat_nxt;
			latch_en_r <= latch_en_nxt;
			mask_r     <= mask_nxt;
			ctrl_r     <= ctrl_nxt;
		end
	end

	assign wb_ack_o = ack_r;
	assign wb_dat_o = dat_r;

	// ****************************************************************
	// Event sources and flags
	// ****************************************************************

	logic      adma_sel;
	logic      gap_evt;
	flag_vec_t set_vec;
	flag_vec_t en_vec;

	assign adma_sel = ctrl_r[`EVT_BIT_ADMA_SEL];

	// Halt at the gap: data line idle for reads, write activity for writes.
	assign gap_evt = gap_stop_request & (read_direction ? dla_fall : wra_fall); // RULE_04

	// Event set terms for each flag.
	always_comb
	begin
		set_vec = '0;
		set_vec[`EVT_BIT_BUF_WR] = bwe_rise; // RULE_01
		set_vec[`EVT_BIT_DMA] = adma_sel ? (adma_desc_done & adma_desc_int) // RULE_03
			: (sdma_boundary_hit & ~sdma_last_block); // RULE_02
		set_vec[`EVT_BIT_GAP] = gap_evt;
		set_vec[`EVT_BIT_XFER_DONE] = (read_direction & rda_fall) // RULE_05
			| (~read_direction & dla_fall) // RULE_06
			| busy_released // RULE_07
			| gap_evt; // RULE_08
		set_vec[`EVT_BIT_CMD_DONE] = resp_received & resp_crc_ok & ~resp_auto_cmd; // RULE_09 RULE_10
		set_vec[5] = tmo_evt;
	end

	// The timeout flag always latches; the others follow their enables.
	assign en_vec = {1'b1, latch_en_r[4:0]}; // RULE_14

	// One sticky cell per flag.
	genvar gi;
	generate
		for (gi = 0; gi < NUM_FLAGS; gi++)
		begin : g_flag
			event_flag u_flag
			(
				.clk      (clk),
				.reset    (reset),
				.set_evt  (set_vec[gi]),
				.latch_en (en_vec[gi]),
				.clr      (clr_vec[gi]),
				.q        (flags[gi])
			);
		end
	endgenerate

	// Level interrupt while any unmasked status bit is set.
	assign irq         = |(nstat & mask_r);
	assign cmd_timeout = flags[5];

	// ****************************************************************
	// Checks
	// ****************************************************************

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	sequence tmo_tick_s;
		wstate_r == WAIT_RESP && !resp_received && card_clk_tick;
	endsequence

	sequence tmo_last_s;
		tmo_tick_s and wait_cnt_r == LAST_TICK;
	endsequence

	buf_ready_set_a: assert property ( // RULE_01
		$rose(buf_write_enable) && latch_en_r[4] |=> flags[4])
		else $error("buffer write ready not set");

	sdma_boundary_a: assert property ( // RULE_02
		!adma_sel && sdma_boundary_hit && latch_en_r[3] |=> flags[3] == !$past(sdma_last_block) || $past(flags[3]) && !$past(clr_vec[3]))
		else $error("simple dma flag wrong");

	adma_desc_a: assert property ( // RULE_03
		adma_sel && adma_desc_done && adma_desc_int && latch_en_r[3] |=> flags[3])
		else $error("advanced dma flag not set");

	gap_halt_a: assert property ( // RULE_04
		gap_stop_request && !read_direction && $fell(write_xfer_active) && &latch_en_r[2:1] |=> flags[2] && flags[1])
		else $error("gap halt not flagged");

	read_done_a: assert property ( // RULE_05
		read_direction && $fell(read_xfer_active) && latch_en_r[1] |=> flags[1])
		else $error("read complete not set");

	write_done_a: assert property ( // RULE_06
		!read_direction && $fell(data_line_active) && latch_en_r[1] |=> flags[1])
		else $error("write complete not set");

	busy_done_a: assert property ( // RULE_07
		busy_released && latch_en_r[1] |=> flags[1])
		else $error("busy release not flagged");

	cmd_done_a: assert property ( // RULE_09
		$rose(flags[0]) |-> $past(resp_received && resp_crc_ok && !resp_auto_cmd))
		else $error("command complete without good response");

	auto_cmd_a: assert property ( // RULE_10
		resp_received && resp_auto_cmd && !flags[0] |=> !flags[0])
		else $error("auto command set command complete");

	resp_timeout_a: assert property ( // RULE_11
		tmo_last_s |=> cmd_timeout ##0 wstate_r == WAIT_IDLE)
		else $error("timeout not raised after full wait");

	tmo_early_a: assert property ( // RULE_11
		$rose(cmd_timeout) |-> $past(wait_cnt_r) == LAST_TICK)
		else $error("timeout raised early");

	latch_gate_a: assert property ( // RULE_14
		!latch_en_r[1] && !flags[1] |=> !flags[1])
		else $error("flag latched while disabled");

	// The index is compared in place so that only sampled values are used.
	w1c_clear_a: assert property ( // RULE_15
		wr_take && wb_adr_i[7:2] == `EVT_IDX_NSTAT && wb_sel_i[0] && !wb_dat_i[4]
		&& flags[4] |=> flags[4])
		else $error("zero write cleared a flag");

	w1c_set_a: assert property ( // RULE_15
		clr_vec[4] && !set_vec[4] |=> !flags[4])
		else $error("one write did not clear");

endmodule : normal_event_bank

// [tb/card_model.sv]
// Behavioural card model that answers commands on the card side of the event bank.
`timescale 1ns/100ps

module card_model
(
	input  wire logic clk,
	input  wire logic reset,
	output logic      cmd_issued,
	output logic      resp_received,
	output logic      resp_crc_ok,
	output logic      resp_auto_cmd,
	output logic      card_clk_tick
);
	// ****************************************************************
	// Command and response sequencing
	// ****************************************************************
	// The card clock only ticks while a response is awaited, as a real card clock may stop.
	initial
	begin
		cmd_issued = 1'b0;
		resp_received = 1'b0;
		resp_crc_ok = 1'b0;
		resp_auto_cmd = 1'b0;
		card_clk_tick = 1'b0;
	end

	// Issues one command, runs dly card clocks, then answers if rsp is set.
	task automatic command(input logic rsp, input logic crc, input logic aut, input int dly);
		while (reset) @(posedge clk);
		@(posedge clk) cmd_issued <= 1'b1;
		@(posedge clk) cmd_issued <= 1'b0;
		repeat (dly)
		begin
			@(posedge clk) card_clk_tick <= 1'b1;
			@(posedge clk) card_clk_tick <= 1'b0;
		end
		if (rsp)
		begin
			@(posedge clk);
			resp_crc_ok <= crc;
			resp_auto_cmd <= aut;
			resp_received <= 1'b1;
			@(posedge clk);
			resp_received <= 1'b0;
			// Released qualifiers show the inverse so stale values are never trusted.
			resp_crc_ok <= ~crc;
			resp_auto_cmd <= ~aut;
		end
	endtask : command
endmodule : card_model

// [tb/tb_top.sv]
// Self-checking testbench of the normal event bank.
`timescale 1ns/100ps

`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
	$display("unexpected %s exp %h got %h", nm, e, g); end end

module tb_top;
	logic        clk = 1'b0;
	logic        reset = 1'b1;
	logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [31:0] dat = 32'h0000_0000;
	logic [3:0]  sel = 4'h0;
	logic        bwe = 1'b0, rxa = 1'b0, wxa = 1'b0, dla = 1'b0, rdir = 1'b0, gsr = 1'b0;
	logic        sbh = 1'b0, slb = 1'b0, add = 1'b0, adi = 1'b0, bsy = 1'b0;
	wire logic   cmd_i, rsp_r, rsp_c, rsp_a, tick, cto, irq, ack;
	wire logic [31:0] rdat;
	logic [31:0] exp_q [$];
	logic [31:0] e_v;
	int          num_errors = 0, n_checks = 0, cycles = 0;

	// ****************************************************************
	// Clock, instances and watchers
	// ****************************************************************
	always #25 clk = ~clk;

	normal_event_bank #(.RESP_WAIT_CLKS(4)) i_dut (.clk(clk), .reset(reset), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel),
		.wb_dat_o(rdat), .wb_ack_o(ack), .buf_write_enable(bwe), .read_xfer_active(rxa),
		.write_xfer_active(wxa), .data_line_active(dla), .read_direction(rdir),
		.gap_stop_request(gsr), .sdma_boundary_hit(sbh), .sdma_last_block(slb),
		.adma_desc_done(add), .adma_desc_int(adi), .busy_released(bsy), .cmd_issued(cmd_i),
		.resp_received(rsp_r), .resp_crc_ok(rsp_c), .resp_auto_cmd(rsp_a),
		.card_clk_tick(tick), .cmd_timeout(cto), .irq(irq));

	card_model i_card (.clk(clk), .reset(reset), .cmd_issued(cmd_i), .resp_received(rsp_r),
		.resp_crc_ok(rsp_c), .resp_auto_cmd(rsp_a), .card_clk_tick(tick));

	// Read data is compared against the oldest noted expectation at the ack edge.
	always @(posedge clk)
	begin
		if (ack === 1'b1 && we === 1'b0)
		begin
			e_v = exp_q.pop_front();
			`CHK("rdata", e_v, rdat)
		end
	end

	// A hung handshake is cut short here and counted as a mismatch.
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			num_errors++;
			complete_run();
		end
	end

	// ****************************************************************
	// Tasks
	// ****************************************************************
	task complete_run;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : complete_run

	// One classic Wishbone cycle; the request is held until ack is sampled high.
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		sel <= 4'hF;
		@(posedge clk);
		while (ack !== 1'b1) @(posedge clk);
		cyc <= 1'b0;
		stb <= 1'b0;
		dat <= ~d;
	endtask : wb

	task rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		wb(1'b0, a, 32'h0000_0000);
	endtask : rd

	// Pulses one event source for a cycle; a fall is seen on the cycle after.
	task fire(input int k);
		@(posedge clk);
		case (k)
			0: rxa <= 1'b1;
			1: dla <= 1'b1;
			2: wxa <= 1'b1;
			3: bsy <= 1'b1;
			4: sbh <= 1'b1;
			default: add <= 1'b1;
		endcase
		@(posedge clk) {rxa, dla, wxa, bsy, sbh, add} <= 6'b00_0000;
	endtask : fire

	// Checks the status, then clears the five normal event flags with a write of ones.
	task chkclr(input logic [31:0] v);
		rd(8'hC0, v);
		wb(1'b1, 8'hC0, 32'h0000_001F);
	endtask : chkclr

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial
	begin
		void'($urandom(32'habec99cf));
		repeat (12) @(posedge clk);
		reset <= 1'b0;
		rd(8'hC0, 32'h0000_0000);
		rd(8'hD0, 32'h0000_001F);
		rd(8'hE0, 32'h0000_0000);
		rd(8'h44, 32'h0000_0000);
		@(posedge clk) bwe <= 1'b1;
		rd(8'hC0, 32'h0000_0010);
		wb(1'b1, 8'hC0, 32'h0000_0000);
		rd(8'hC0, 32'h0000_0010);
		wb(1'b1, 8'hC0, 32'h0000_0010);
		rd(8'hC0, 32'h0000_0000);
		wb(1'b1, 8'hE0, 32'h0000_0010);
		@(posedge clk) bwe <= 1'b0;
		@(posedge clk) bwe <= 1'b1;
		repeat (2) @(negedge clk);
		`CHK("irq", 1'b1, irq)
		wb(1'b1, 8'hC0, 32'h0000_0010);
		@(negedge clk);
		`CHK("irq", 1'b0, irq)
		wb(1'b1, 8'hE0, 32'h0000_0000);
		rdir <= 1'b1;
		fire(0);
		chkclr(32'h0000_0002);
		rdir <= 1'b0;
		fire(1);
		chkclr(32'h0000_0002);
		fire(2);
		chkclr(32'h0000_0000);
		gsr <= 1'b1;
		rdir <= 1'b1;
		fire(1);
		chkclr(32'h0000_0006);
		rdir <= 1'b0;
		fire(2);
		chkclr(32'h0000_0006);
		gsr <= 1'b0;
		fire(3);
		chkclr(32'h0000_0002);
		fire(4);
		chkclr(32'h0000_0008);
		slb <= 1'b1;
		fire(4);
		chkclr(32'h0000_0000);
		wb(1'b1, 8'hF0, 32'h0000_0001);
		adi <= 1'b1;
		fire(5);
		chkclr(32'h0000_0008);
		adi <= 1'b0;
		fire(5);
		chkclr(32'h0000_0000);
		wb(1'b1, 8'hF0, 32'h0000_0000);
		wb(1'b1, 8'hD0, 32'h0000_0000);
		fire(3);
		rd(8'hC0, 32'h0000_0000);
		wb(1'b1, 8'hD0, 32'h0000_001F);
		i_card.command(1'b1, 1'b1, 1'b0, $urandom % 3);
		chkclr(32'h0000_0001);
		i_card.command(1'b1, 1'b0, 1'b0, $urandom % 3);
		chkclr(32'h0000_0000);
		i_card.command(1'b1, 1'b1, 1'b1, $urandom % 3);
		chkclr(32'h0000_0000);
		i_card.command(1'b0, 1'b1, 1'b0, 6);
		@(negedge clk);
		`CHK("cmd_timeout", 1'b1, cto)
		rd(8'hC0, 32'h0000_8000);
		rd(8'hC8, 32'h0000_0001);
		wb(1'b1, 8'hC8, 32'h0000_0001);
		@(negedge clk);
		`CHK("cmd_timeout", 1'b0, cto)
		i_card.command(1'b1, 1'b1, 1'b0, 4 + $urandom % 3);
		rd(8'hC0, 32'h0000_8001);
		rd(8'hC8, 32'h0000_0001);
		wb(1'b1, 8'hC8, 32'h0000_0001);
		chkclr(32'h0000_0001);
		fire(3);
		chkclr(32'h0000_0002);
		rd(8'hC8, 32'h0000_0000);
		complete_run();
	end
endmodule : tb_top
